// ### hdl/ttc_pkg.sv
// Constants, register map and types of the tach and trigger conditioner
package ttc_pkg;

    // Clock and time base
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
    localparam int unsigned STANDSTILL_S = 60;
    localparam int unsigned STANDSTILL_MS_DEF = STANDSTILL_S * MS_PER_S;

    // Register byte addresses
    localparam int ADR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PPU = 8'h04;
    localparam logic [7:0] REG_SCALE = 8'h08;
    localparam logic [7:0] REG_SPEED = 8'h0C;
    localparam logic [7:0] REG_DEBOUNCE = 8'h10;
    localparam logic [7:0] REG_TRIG_REF = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_TRAVEL = 8'h1C;

    // Trigger source selection
    typedef enum logic [1:0] {
        TTC_TS_HW = 2'b00,
        TTC_TS_SW = 2'b01,
        TTC_TS_CONT = 2'b10
    } ttc_trig_src_e;

    // Control register layout, bit 0 at the bottom
    typedef struct packed {
        logic sw_trig;
        logic pol_low;
        logic [1:0] trig_src;
        logic tach_laser_ctl;
        logic laser_en;
        logic unit_fpm;
        logic tach_int;
    } ttc_ctrl_s;

    localparam int CTRL_W = 8;
    localparam logic [7:0] CTRL_RST = 8'h06;

    // Fixed point formats and reset values
    localparam int PPU_FRAC = 8;
    localparam int SCALE_FRAC = 12;
    localparam logic [15:0] PPU_RST = 16'h1000;
    localparam logic [15:0] SCALE_RST = 16'h1000;
    localparam logic [15:0] SCALE_ONE = 16'h1000;
    localparam logic [15:0] SPEED_RST = 16'h07D0;
    localparam logic [15:0] DEBOUNCE_RST = 16'h0005;
    localparam logic [15:0] TRIG_REF_RST = 16'h003C;

    // Speed limits in tenths of cm/s and tenths of ft/min
    localparam logic [15:0] SPEED_MIN_CM = 16'h0032;
    localparam logic [15:0] SPEED_MAX_CM = 16'h0BEA;
    localparam logic [15:0] SPEED_MIN_FPM = 16'h0064;
    localparam logic [15:0] SPEED_MAX_FPM = 16'h1770;

    // Travel is counted in tenths of a unit
    localparam int unsigned DIST_TENTHS = 10;
    localparam int unsigned FPM_DIV = 5;
    localparam logic [39:0] NCO_THR_CM = 40'(CLK_HZ) * 40'(DIST_TENTHS << PPU_FRAC);
    localparam logic [39:0] NCO_THR_FPM = NCO_THR_CM * 40'(FPM_DIV);

    // Status bit positions
    localparam int ST_TRIG = 0;
    localparam int ST_LASER = 1;
    localparam int ST_STILL = 2;
    localparam int ST_PEND = 3;
    localparam int ST_LEVEL = 4;

endpackage : ttc_pkg

// ### hdl/ttc_top.sv
// Tach and trigger conditioner with classic Wishbone register slave
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module ttc_top
    import ttc_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYCLES_DEF,
    parameter int unsigned STANDSTILL_MS = STANDSTILL_MS_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Sensor pins
    input wire logic tach_in,
    input wire logic trig_in,
    // Conditioned outputs
    output logic trig_active,
    output logic laser_on,
    output logic pkg_at_head
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter checks
    if (MS_CYCLES < 2 || MS_CYCLES > 65535) begin : g_bad_ms
        $error("MS_CYCLES out of range");
    end
    if (STANDSTILL_MS < 1 || STANDSTILL_MS > 65535) begin : g_bad_still
        $error("STANDSTILL_MS out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    ttc_ctrl_s ctrl, next_ctrl;
    logic [15:0] ppu, next_ppu;
    logic [15:0] scale, next_scale;
    logic [15:0] speed, next_speed;
    logic [15:0] debounce, next_debounce;
    logic [15:0] trig_ref, next_trig_ref;
    logic [31:0] next_dat;
    logic next_ack;
    logic [31:0] status;
    logic [31:0] travel;
    logic [31:0] merged;
    logic wr;

    // Merge written byte lanes into an old value
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Bus decode and register writes; ack is one cycle late and drops after one cycle
    always_comb begin
        wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_ctrl = ctrl;
        next_ppu = ppu;
        next_scale = scale;
        next_speed = speed;
        next_debounce = debounce;
        next_trig_ref = trig_ref;
        next_dat = 32'h0000_0000;
        merged = 32'h0000_0000;
        unique case (wb_adr_i)
            REG_CTRL: begin
                next_dat = 32'(ctrl);
                merged = merge(32'(ctrl), wb_dat_i, wb_sel_i);
                if (wr) next_ctrl = ttc_ctrl_s'(merged[CTRL_W-1:0]);
            end
            REG_PPU: begin
                next_dat = 32'(ppu);
                merged = merge(32'(ppu), wb_dat_i, wb_sel_i);
                if (wr) next_ppu = merged[15:0];
            end
            REG_SCALE: begin
                next_dat = 32'(scale);
                merged = merge(32'(scale), wb_dat_i, wb_sel_i);
                if (wr) next_scale = merged[15:0];
            end
            REG_SPEED: begin
                next_dat = 32'(speed);
                merged = merge(32'(speed), wb_dat_i, wb_sel_i);
                if (wr) next_speed = merged[15:0];
            end
            REG_DEBOUNCE: begin
                next_dat = 32'(debounce);
                merged = merge(32'(debounce), wb_dat_i, wb_sel_i);
                if (wr) next_debounce = merged[15:0];
            end
            REG_TRIG_REF: begin
                next_dat = 32'(trig_ref);
                merged = merge(32'(trig_ref), wb_dat_i, wb_sel_i);
                if (wr) next_trig_ref = merged[15:0];
            end
            REG_STATUS: next_dat = status;
            REG_TRAVEL: next_dat = travel;
            default: next_dat = 32'h0000_0000;  // Unmapped reads zero, writes dropped
        endcase
        if (!next_ack) next_dat = 32'h0000_0000;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl <= ttc_ctrl_s'(CTRL_RST);
            ppu <= PPU_RST;
            scale <= SCALE_RST;
            speed <= SPEED_RST;
            debounce <= DEBOUNCE_RST;
            trig_ref <= TRIG_REF_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            ppu <= next_ppu;
            scale <= next_scale;
            speed <= next_speed;
            debounce <= next_debounce;
            trig_ref <= next_trig_ref;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection
    logic tach_m, tach_s, tach_d, trig_m, trig_s;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tach_m <= 1'b0;
            tach_s <= 1'b0;
            tach_d <= 1'b0;
            trig_m <= 1'b0;
            trig_s <= 1'b0;
        end else begin
            tach_m <= tach_in;
            tach_s <= tach_m;
            tach_d <= tach_s;
            trig_m <= trig_in;
            trig_s <= trig_m;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective pulses per unit, scaled and saturated
    logic [31:0] ppu_prod;
    logic [15:0] eff_ppu, next_eff_ppu;
    logic [15:0] speed_eff;
    logic [39:0] nco_thr;

    always_comb begin
        ppu_prod = 32'(ppu) * 32'(scale);
        next_eff_ppu = (|ppu_prod[31:SCALE_FRAC+16]) ? 16'hFFFF
                                                      : ppu_prod[SCALE_FRAC +: 16];
        // Clamp the programmed speed into the legal band of its unit
        if (ctrl.unit_fpm) begin
            speed_eff = (speed < SPEED_MIN_FPM) ? SPEED_MIN_FPM :
                        (speed > SPEED_MAX_FPM) ? SPEED_MAX_FPM : speed;
            nco_thr = NCO_THR_FPM;
        end else begin
            speed_eff = (speed < SPEED_MIN_CM) ? SPEED_MIN_CM :
                        (speed > SPEED_MAX_CM) ? SPEED_MAX_CM : speed;
            nco_thr = NCO_THR_CM;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal tach oscillator and pulse source selection
    logic [39:0] nco_acc, next_nco_acc;
    logic [39:0] nco_sum;
    logic nco_pulse, next_nco_pulse;
    logic tach_pulse;

    always_comb begin
        nco_sum = nco_acc + 40'(speed_eff) * 40'(eff_ppu);
        next_nco_pulse = 1'b0;
        next_nco_acc = nco_sum;
        if (!ctrl.tach_int) begin
            next_nco_acc = 40'h00_0000_0000;
        end else if (nco_sum >= nco_thr) begin
            next_nco_acc = nco_sum - nco_thr;
            next_nco_pulse = 1'b1;
        end
        // External pulses are ignored while the internal source runs
        tach_pulse = ctrl.tach_int ? nco_pulse : (tach_s && !tach_d);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            eff_ppu <= PPU_RST;
            nco_acc <= 40'h00_0000_0000;
            nco_pulse <= 1'b0;
        end else begin
            eff_ppu <= next_eff_ppu;
            nco_acc <= next_nco_acc;
            nco_pulse <= next_nco_pulse;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Travel in tenths of a unit: each pulse adds 2560 units of 1/256 pulse
    logic [23:0] dist_acc, next_dist_acc;
    logic [31:0] next_travel;
    logic [23:0] dist_add;

    always_comb begin
        dist_add = tach_pulse ? 24'(DIST_TENTHS << PPU_FRAC) : 24'h00_0000;
        next_dist_acc = dist_acc + dist_add;
        next_travel = travel;
        if (eff_ppu != 16'h0000 && dist_acc >= 24'(eff_ppu)) begin
            next_dist_acc = dist_acc - 24'(eff_ppu) + dist_add;
            next_travel = travel + 32'h0000_0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dist_acc <= 24'h00_0000;
            travel <= 32'h0000_0000;
        end else begin
            dist_acc <= next_dist_acc;
            travel <= next_travel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick and belt standstill timer
    logic [15:0] ms_cnt, next_ms_cnt;
    logic ms_tick;
    logic [15:0] still_ms, next_still_ms;
    logic still;
    logic next_laser;

    always_comb begin
        ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));
        next_ms_cnt = ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
        still = (still_ms >= 16'(STANDSTILL_MS));
        next_still_ms = still_ms;
        if (tach_pulse) begin
            next_still_ms = 16'h0000;
        end else if (ms_tick && !still) begin
            next_still_ms = still_ms + 16'h0001;
        end
        next_laser = ctrl.laser_en && !(ctrl.tach_laser_ctl && still);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ms_cnt <= 16'h0000;
            still_ms <= 16'h0000;
            laser_on <= 1'b0;
        end else begin
            ms_cnt <= next_ms_cnt;
            still_ms <= next_still_ms;
            laser_on <= next_laser;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger debounce, polarity and source selection
    logic acc_lvl, next_acc_lvl;
    logic [15:0] dbn_cyc, next_dbn_cyc;
    logic [15:0] dbn_ms, next_dbn_ms;
    logic next_trig;
    logic dbn_done;

    always_comb begin
        next_acc_lvl = acc_lvl;
        next_dbn_cyc = 16'h0000;
        next_dbn_ms = 16'h0000;
        dbn_done = (dbn_ms >= debounce);
        if (trig_s != acc_lvl) begin
            if (dbn_done) begin
                next_acc_lvl = trig_s;
            end else if (dbn_cyc == 16'(MS_CYCLES - 1)) begin
                next_dbn_ms = dbn_ms + 16'h0001;
            end else begin
                next_dbn_cyc = dbn_cyc + 16'h0001;
                next_dbn_ms = dbn_ms;
            end
        end  // Level back at accepted value clears both counts
        unique case (ttc_trig_src_e'(ctrl.trig_src))
            TTC_TS_HW: next_trig = ctrl.pol_low ? !acc_lvl : acc_lvl;
            TTC_TS_SW: next_trig = ctrl.sw_trig;
            TTC_TS_CONT: next_trig = 1'b1;
            default: next_trig = ctrl.pol_low ? !acc_lvl : acc_lvl;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            acc_lvl <= 1'b0;
            dbn_cyc <= 16'h0000;
            dbn_ms <= 16'h0000;
            trig_active <= 1'b0;
        end else begin
            acc_lvl <= next_acc_lvl;
            dbn_cyc <= next_dbn_cyc;
            dbn_ms <= next_dbn_ms;
            trig_active <= next_trig;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Package position: trigger start plus offset gives arrival at the head
    logic trig_d, next_pend, pend;
    logic [31:0] target, next_target;
    logic next_at_head;
    logic trig_rise;

    always_comb begin
        trig_rise = trig_active && !trig_d;
        next_pend = pend;
        next_target = target;
        next_at_head = 1'b0;
        if (pend && travel >= target) begin
            next_pend = 1'b0;
            next_at_head = 1'b1;
        end
        if (trig_rise) begin
            next_pend = 1'b1;
            next_target = travel + 32'(trig_ref);
        end
        status = 32'h0000_0000;
        status[ST_TRIG] = trig_active;
        status[ST_LASER] = laser_on;
        status[ST_STILL] = still;
        status[ST_PEND] = pend;
        status[ST_LEVEL] = acc_lvl;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            trig_d <= 1'b0;
            pend <= 1'b0;
            target <= 32'h0000_0000;
            pkg_at_head <= 1'b0;
        end else begin
            trig_d <= trig_active;
            pend <= next_pend;
            target <= next_target;
            pkg_at_head <= next_at_head;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_sync;
        trig_s == $past(trig_in, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("trigger sync depth wrong");

    property p_clamp;
        ctrl.tach_int |-> (ctrl.unit_fpm
            ? (speed_eff >= SPEED_MIN_FPM && speed_eff <= SPEED_MAX_FPM)
            : (speed_eff >= SPEED_MIN_CM && speed_eff <= SPEED_MAX_CM));
    endproperty
    a_clamp: assert property (p_clamp) else $error("speed outside band");

    property p_ext_ignored;
        ctrl.tach_int && !nco_pulse |-> !tach_pulse;
    endproperty
    a_ext_ignored: assert property (p_ext_ignored) else $error("external pulse used");

    property p_scale_one;
        (scale == SCALE_ONE && $stable(ppu)) |=> eff_ppu == $past(ppu);
    endproperty
    a_scale_one: assert property (p_scale_one) else $error("unity scale changed ppu");

    property p_travel;
        (eff_ppu != 16'h0000 && dist_acc >= 24'(eff_ppu))
            |=> travel == $past(travel) + 32'h0000_0001;
    endproperty
    a_travel: assert property (p_travel) else $error("travel missed a unit");

    property p_pol_high;
        (ctrl.trig_src == TTC_TS_HW && !ctrl.pol_low && acc_lvl) ##1 $stable(ctrl) |-> trig_active;
    endproperty
    a_pol_high: assert property (p_pol_high) else $error("active high wrong");

    property p_pol_low;
        (ctrl.trig_src == TTC_TS_HW && ctrl.pol_low && !acc_lvl) ##1 $stable(ctrl) |-> trig_active;
    endproperty
    a_pol_low: assert property (p_pol_low) else $error("active low wrong");

    property p_debounce;
        acc_lvl != $past(acc_lvl) |-> $past(dbn_ms) >= $past(debounce);
    endproperty
    a_debounce: assert property (p_debounce) else $error("change taken early");

    property p_restart;
        trig_s == acc_lvl |=> dbn_cyc == 16'h0000 && dbn_ms == 16'h0000;
    endproperty
    a_restart: assert property (p_restart) else $error("debounce did not restart");

    property p_laser_off;
        (ctrl.tach_laser_ctl && still) ##1 $stable(ctrl) |-> !laser_on;
    endproperty
    a_laser_off: assert property (p_laser_off) else $error("laser on at standstill");

    property p_cont;
        ctrl.trig_src == TTC_TS_CONT |=> trig_active;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous trigger inactive");

    property p_target;
        trig_rise |=> target == $past(travel) + 32'($past(trig_ref));
    endproperty
    a_target: assert property (p_target) else $error("head target wrong");

    c_hw_accept: cover property (ctrl.trig_src == TTC_TS_HW && acc_lvl != $past(acc_lvl));
    c_laser_off: cover property ($fell(laser_on) && still);
    c_at_head: cover property (pkg_at_head);
    c_int_pulse: cover property (ctrl.tach_int && nco_pulse);

endmodule : ttc_top

// ### test/testbench.sv
// Self-checking bench of the tach and trigger conditioner
`timescale 1ns/1ps
module testbench;
    import ttc_pkg::*;
    localparam int unsigned MSC = 4;
    localparam int unsigned STILL_MS = 5;
    logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic tach_in, trig_in, trig_active, laser_on, pkg_at_head;
    int err_total = 0;
    int check_count = 0;
    int pkg_seen = 0;

    ttc_top #(.MS_CYCLES(MSC), .STANDSTILL_MS(STILL_MS)) ttc_top_i (.ref_clk(ref_clk),
        .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .tach_in(tach_in), .trig_in(trig_in), .trig_active(trig_active),
        .laser_on(laser_on), .pkg_at_head(pkg_at_head));
    ttc_sensor_model ttc_sensor_model_i (.ref_clk(ref_clk), .tach_in(tach_in),
        .trig_in(trig_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock of 100 ns period
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Counts head arrival pulses
    always @(posedge ref_clk) begin
        if (pkg_at_head === 1'b1) begin
            pkg_seen <= pkg_seen + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    // Classic single Wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                           input logic [3:0] sel, output logic [31:0] rd);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        wb_xfer(1'b1, a, d, 4'hF, x);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        wb_xfer(1'b0, a, 32'h0000_0000, 4'hF, d);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    ////////////////////////////////////////////////////////////////////////////
    // Reset values, then an unmapped place that reads zero
    task automatic t_reset_values;
        logic [7:0] adr [7] = '{REG_CTRL, REG_PPU, REG_SCALE, REG_SPEED, REG_DEBOUNCE,
                                REG_TRIG_REF, 8'h20};
        logic [31:0] exp [7] = '{32'(CTRL_RST), 32'(PPU_RST), 32'(SCALE_RST), 32'(SPEED_RST),
                                 32'(DEBOUNCE_RST), 32'(TRIG_REF_RST), 32'h0000_0000};
        logic [31:0] d;
        cyc(2);
        check(32'(laser_on), 32'h0000_0001, "laser after reset");
        wr(8'h20, 32'hFFFF_FFFF);
        for (int i = 0; i < 7; i++) begin
            rd(adr[i], d);
            check(d, exp[i], "reset value");
        end
        wb_xfer(1'b1, REG_TRIG_REF, 32'hFFFF_FF2A, 4'h1, d);
        rd(REG_TRIG_REF, d);
        check(d, 32'h0000_002A, "byte lane write");
        wr(REG_TRIG_REF, 32'(TRIG_REF_RST));
    endtask : t_reset_values

    // A bounce that returns early restarts the count; then low polarity
    task automatic t_debounce;
        int n;
        wr(REG_DEBOUNCE, 32'h0000_0004);
        wr(REG_CTRL, 32'h0000_0004);
        ttc_sensor_model_i.set_trig(1'b1);
        cyc(12);
        ttc_sensor_model_i.set_trig(1'b0);
        cyc(2);
        ttc_sensor_model_i.set_trig(1'b1);
        n = 0;
        while (trig_active !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            n++;
        end
        check(32'(n >= 16 && n <= 30), 32'h0000_0001, "debounce span");
        wr(REG_CTRL, 32'h0000_0044);
        cyc(3);
        check(32'(trig_active), 32'h0000_0000, "low polarity, pin high");
        ttc_sensor_model_i.set_trig(1'b0);
        cyc(40);
        check(32'(trig_active), 32'h0000_0001, "low polarity, pin low");
        ttc_sensor_model_i.set_trig(1'b1);
        cyc(40);
    endtask : t_debounce

    // Each trigger source with the pin held high
    task automatic t_sources;
        logic [31:0] ctl [5] = '{32'h0000_0014, 32'h0000_0094, 32'h0000_0024, 32'h0000_0044,
                                 32'h0000_0004};
        logic exp [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 5; i++) begin
            wr(REG_CTRL, ctl[i]);
            cyc(3);
            check(32'(trig_active), 32'(exp[i]), "trigger source");
        end
    endtask : t_sources

    // Sixteen pulses at three scale factors
    task automatic t_travel;
        logic [31:0] scl [3] = '{32'h0000_1000, 32'h0000_0800, 32'h0000_2000};
        logic [31:0] exp [3] = '{32'h0000_000A, 32'h0000_0014, 32'h0000_0005};
        logic [31:0] t0, t1;
        for (int i = 0; i < 3; i++) begin
            wr(REG_SCALE, scl[i]);
            rd(REG_TRAVEL, t0);
            ttc_sensor_model_i.tach_pulses(16);
            cyc(4);
            rd(REG_TRAVEL, t1);
            check(t1 - t0, exp[i], "travel per 16 pulses");
        end
        wr(REG_SCALE, 32'h0000_1000);
    endtask : t_travel

    // Head pulse comes on the pulse that completes the reference distance
    task automatic t_head;
        int p0;
        wr(REG_TRIG_REF, 32'h0000_000A);
        wr(REG_CTRL, 32'h0000_0014);
        wr(REG_CTRL, 32'h0000_0094);
        p0 = pkg_seen;
        ttc_sensor_model_i.tach_pulses(15);
        cyc(4);
        check(32'(pkg_seen - p0), 32'h0000_0000, "head pulse early");
        ttc_sensor_model_i.tach_pulses(1);
        cyc(4);
        check(32'(pkg_seen - p0), 32'h0000_0001, "head pulse");
    endtask : t_head

    // Laser drops after the standstill time and returns with motion
    task automatic t_laser;
        wr(REG_CTRL, 32'h0000_000C);
        ttc_sensor_model_i.tach_pulses(1);
        cyc(10);
        check(32'(laser_on), 32'h0000_0001, "laser while moving");
        cyc(40);
        check(32'(laser_on), 32'h0000_0000, "laser after standstill");
        ttc_sensor_model_i.tach_pulses(1);
        cyc(6);
        check(32'(laser_on), 32'h0000_0001, "laser after motion");
    endtask : t_laser

    // Internal source at an over-range speed in both units, outside pulses ignored
    task automatic t_internal;
        logic [31:0] ctl [2] = '{32'h0000_0005, 32'h0000_0007};
        int lo [2] = '{5, 2};
        int hi [2] = '{7, 3};
        logic [31:0] t0, t1;
        wr(REG_SPEED, 32'h0000_FFFF);
        for (int i = 0; i < 2; i++) begin
            wr(REG_CTRL, ctl[i]);
            rd(REG_TRAVEL, t0);
            ttc_sensor_model_i.tach_pulses(16);
            cyc(19900);
            rd(REG_TRAVEL, t1);
            check(32'((t1 - t0) >= lo[i] && (t1 - t0) <= hi[i]), 32'h0000_0001,
                  "internal travel");
        end
    endtask : t_internal

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        cyc(6);
        rst_n <= 1'b1;
        t_reset_values();
        t_debounce();
        t_sources();
        t_travel();
        t_head();
        t_laser();
        t_internal();
        conclude();
    end

    // Watchdog well beyond the planned run
    initial begin
        cyc(80000);
        err_total++;
        conclude();
    end
endmodule : testbench

// ### test/ttc_sensor_model.sv
// Behavioural tachometer encoder and photoelectric trigger sensor
`timescale 1ns/1ps
module ttc_sensor_model (
    // Clock
    input wire logic ref_clk,
    // Sensor pins
    output logic tach_in,
    output logic trig_in
);
    ////////////////////////////////////////////////////////////////////////////
    // Both pins idle low until a scenario moves them
    initial begin
        tach_in = 1'b0;
        trig_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Encoder pulses, three cycles high and three low, so the synchroniser sees each
    task automatic tach_pulses(input int n);
        repeat (n) begin
            @(posedge ref_clk) tach_in <= 1'b1;
            repeat (3) @(posedge ref_clk);
            tach_in <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
    endtask : tach_pulses

    // Photo sensor reports a package by its output level
    task automatic set_trig(input logic lvl);
        @(posedge ref_clk) trig_in <= lvl;
    endtask : set_trig
endmodule : ttc_sensor_model
